/* hdl/igp_pkg.sv */
package igp_pkg;

   // Host-side timing, in nanoseconds as documented
   localparam int unsigned CLK_PERIOD_NS        = 10;
   localparam int unsigned BLANKING_INTERVAL_NS = 3000;
   localparam int unsigned MIN_ON_PULSE_NS      = 2000;
   localparam int unsigned MIN_OFF_LO_NS        = 2500;
   localparam int unsigned MIN_OFF_HI_NS        = 2900;

   // Least times round up to whole cycles
   localparam int unsigned BLANK_CYC =
      (BLANKING_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned MIN_ON_CYC =
      (MIN_ON_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned MIN_OFF_LO_CYC =
      (MIN_OFF_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned MIN_OFF_HI_CYC =
      (MIN_OFF_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int unsigned CNT_W   = 10;
   localparam int unsigned NPHASE  = 3;

   // Per-phase command from the PWM source
   typedef struct packed {
      logic hi_on;
      logic lo_on;
   } igp_cmd_t;

   // Per-phase gate drive to the power module
   typedef struct packed {
      logic hi_gate;
      logic lo_gate;
   } igp_gate_t;

   typedef enum logic [1:0] {
      IGP_OFF   = 2'b00,
      IGP_BLANK = 2'b01,
      IGP_ON_HI = 2'b11,
      IGP_ON_LO = 2'b10
   } igp_leg_t;

endpackage

/* hdl/igp_leg.sv */
`timescale 1ns/1ns
module igp_leg
   import igp_pkg::*;
#(
   parameter int unsigned BLANK  = BLANK_CYC,
   parameter int unsigned MINON  = MIN_ON_CYC,
   parameter int unsigned MINOFF = MIN_OFF_HI_CYC
) (
   // Clock and reset
   input  wire logic      clk,
   input  wire logic      rst_n,
   // Request and inhibit
   input  wire igp_cmd_t  req,
   input  wire logic      inhibit,
   // Gate outputs
   output igp_gate_t      gate
);

   // Refuse at elaboration counts the counter cannot hold
   if (BLANK < 1 || MINON < 1 || MINOFF < 1 ||
       BLANK >= (1 << CNT_W) || MINON >= (1 << CNT_W) ||
       MINOFF >= (1 << CNT_W)) begin : g_bad_count
      $error("igp_leg: timing count out of range");
   end

   localparam logic [CNT_W-1:0] BLANK_C  = CNT_W'(BLANK);
   localparam logic [CNT_W-1:0] MINON_C  = CNT_W'(MINON);
   localparam logic [CNT_W-1:0] MINOFF_C = CNT_W'(MINOFF);

   igp_leg_t         state_r;
   igp_leg_t         state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;

   // Off time covers both blanking and least off width
   function automatic logic [CNT_W-1:0] off_len();
      return (BLANK_C > MINOFF_C) ? BLANK_C : MINOFF_C;
   endfunction

   always_comb begin
      state_nxt   = state_r;
      cnt_nxt     = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
      case (state_r)
         IGP_OFF: begin
            // Fresh rising ON edge always follows an OFF stay
            if (!inhibit && (req.hi_on ^ req.lo_on) && cnt_r == '0) begin
               state_nxt = req.hi_on ? IGP_ON_HI : IGP_ON_LO;
               cnt_nxt   = MINON_C;
            end
         end
         IGP_ON_HI, IGP_ON_LO: begin
            // Hold ON at least the minimum width unless inhibited
            if (inhibit || (cnt_r == '0 &&
                (state_r == IGP_ON_HI ? !req.hi_on : !req.lo_on))) begin
               state_nxt = IGP_BLANK;
               cnt_nxt   = off_len();
            end
         end
         IGP_BLANK: begin
            if (cnt_r == '0)
               state_nxt = IGP_OFF;
         end
         default: begin
            state_nxt = IGP_OFF;
            cnt_nxt   = '0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r   <= IGP_OFF;
         cnt_r     <= '0;
      end else begin
         state_r   <= state_nxt;
         cnt_r     <= cnt_nxt;
      end
   end

   // Gate levels active high, registered
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gate <= '0;
      end else begin
         gate.hi_gate <= (state_nxt == IGP_ON_HI);
         gate.lo_gate <= (state_nxt == IGP_ON_LO);
      end
   end

endmodule

/* hdl/igp_host.sv */
// Summary of operation
// - Host leaves at least 3.0 us between one switch off and partner on.
// - Host makes every ON pulse at least 2.0 us wide, except where a fault cuts it short.
// - Host keeps OFF pulses at least 2.5 us, 2.9 us above 15 A.
// - Fault is active-low open drain; host pulls up, low means fault.
`timescale 1ns/1ns
module igp_host
   import igp_pkg::*;
#(
   parameter int unsigned PHASES         = NPHASE,
   parameter int unsigned HOLDOFF_CYC    = MIN_OFF_HI_CYC,
   parameter logic        HIGH_CURRENT   = 1'b1
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst_n,
   // PWM requests, one pair per phase
   input  wire igp_cmd_t [PHASES-1:0] pwm_req,
   // Gate drive to the module, active high
   output igp_gate_t [PHASES-1:0]  gate,
   // Fault pin of the module, open drain
   input  wire logic                fault_out_n_in,
   output logic                     fault_out_n_out,
   output logic                     fault_out_n_oe,
   // Status to the PWM source
   output logic                     fault_seen,
   output logic                     fault_event
);

   // Refuse at elaboration what the counters cannot hold
   if (PHASES < 1 || PHASES > 8) begin : g_bad_phases
      $error("igp_host: phase count out of range");
   end
   if (HOLDOFF_CYC < 1 || HOLDOFF_CYC >= (1 << CNT_W)) begin : g_bad_hold
      $error("igp_host: hold-off count out of range");
   end

   localparam logic [CNT_W-1:0] HOLD_C = CNT_W'(HOLDOFF_CYC);

   // Fault pin is only ever read; never pulled down by us
   assign fault_out_n_out = 1'b1;
   assign fault_out_n_oe  = 1'b1;

   logic             flt_s1_r;
   logic             flt_s2_r;
   logic             flt_d_r;
   logic             fault_seen_r;
   logic [CNT_W-1:0] hold_r;
   logic             fault_event_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flt_s1_r <= 1'b1;
         flt_s2_r <= 1'b1;
      end else begin
         flt_s1_r <= fault_out_n_in;
         flt_s2_r <= flt_s1_r;
      end
   end

   // Low level on the pulled-up pin means fault
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flt_d_r       <= 1'b1;
         fault_event_r <= 1'b0;
      end else begin
         flt_d_r       <= flt_s2_r;
         fault_event_r <= flt_d_r & ~flt_s2_r;
      end
   end

   // Hold gates off through the fault and a short margin after it,
   // since the module's own latch needs a fresh edge anyway
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fault_seen_r <= 1'b0;
         hold_r       <= '0;
      end else if (!flt_s2_r) begin
         fault_seen_r <= 1'b1;
         hold_r       <= HOLD_C;
      end else if (hold_r != '0) begin
         hold_r       <= hold_r - 1'b1;
      end else begin
         fault_seen_r <= 1'b0;
      end
   end

   assign fault_seen  = fault_seen_r;
   assign fault_event = fault_event_r;

   logic inhibit;
   assign inhibit = fault_seen_r | ~flt_s2_r;

   // Each leg drops to off on fault, then needs a request to come
   // back, which the module sees as the fresh rising ON edge
   genvar gi;
   generate
      for (gi = 0; gi < PHASES; gi++) begin : g_leg
         igp_leg #(
            .BLANK  (BLANK_CYC),
            .MINON  (MIN_ON_CYC),
            .MINOFF (HIGH_CURRENT ? MIN_OFF_HI_CYC : MIN_OFF_LO_CYC)
         ) u_leg (
            .clk     (clk),
            .rst_n   (rst_n),
            .req     (pwm_req[gi]),
            .inhibit (inhibit),
            .gate    (gate[gi])
         );
      end
   endgenerate

endmodule

/* test/igp_host_checker.sv */
`timescale 1ns/1ns
module igp_host_checker
   import igp_pkg::*;
#(
   parameter int unsigned PHASES = NPHASE
) (
   // Clock and reset
   input wire logic                   clk,
   input wire logic                   rst_n,
   // Watched ports
   input wire igp_gate_t [PHASES-1:0] gate,
   input wire logic                   fault_out_n_in,
   input wire logic                   fault_out_n_oe,
   input wire logic                   fault_seen,
   input wire logic                   fault_event
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Phase 0 stands for all legs; they share one design
   logic [9:0] on_c;
   logic [9:0] off_c;
   wire        on0 = gate[0].hi_gate | gate[0].lo_gate;
   always_ff @(posedge clk) begin
      if (!rst_n) off_c <= 10'h3ff;
      else if (on0) off_c <= 10'h000;
      else if (off_c != 10'h3ff) off_c <= off_c + 10'h001;
   end
   always_ff @(posedge clk) begin
      if (!on0) on_c <= 10'h000;
      else if (on_c != 10'h3ff) on_c <= on_c + 10'h001;
   end
   sequence s_turn_on;
      on0 && !$past(on0);
   endsequence
   sequence s_turn_off;
      !on0 && $past(on0);
   endsequence
   property p_blank_gap;
      s_turn_on |-> off_c >= BLANK_CYC;
   endproperty
   property p_no_overlap;
      !(gate[0].hi_gate && gate[0].lo_gate);
   endproperty
   // A fault may cut a pulse short, so those ends are left out
   property p_min_on;
      s_turn_off ##0 !fault_seen |-> on_c >= MIN_ON_CYC;
   endproperty
   property p_fault_read;
      $fell(fault_out_n_in) |-> ##[2:4] (fault_event && fault_seen);
   endproperty
   property p_fault_stops;
      fault_seen [*2] |-> !on0;
   endproperty
   a_blank_gap: assert property (p_blank_gap)
      else $error("gate turned on too soon after off");
   a_no_overlap: assert property (p_no_overlap)
      else $error("both gates of a phase on");
   a_min_on: assert property (p_min_on)
      else $error("on pulse shorter than minimum");
   a_pin_released: assert property (fault_out_n_oe)
      else $error("host drives the fault pin");
   a_fault_read: assert property (p_fault_read)
      else $error("low fault pin not reported");
   a_event_once: assert property (fault_event |=> !fault_event)
      else $error("fault event longer than one cycle");
   a_fault_stops: assert property (p_fault_stops)
      else $error("gate on during fault");
endmodule
bind igp_host igp_host_checker #(.PHASES(PHASES)) u_chk (.clk(clk),
   .rst_n(rst_n), .gate(gate), .fault_out_n_in(fault_out_n_in),
   .fault_out_n_oe(fault_out_n_oe), .fault_seen(fault_seen),
   .fault_event(fault_event));

/* test/igp_pm.sv */
`timescale 1ns/1ns
module igp_pm
   import igp_pkg::*;
#(
   parameter int unsigned FO_CYC = 40
) (
   // Clock and trip flags
   input  wire logic            clk,
   input  wire logic            sc,
   input  wire logic            uvl,
   input  wire logic [2:0]      uvh,
   // Gate commands in, switch states out
   input  wire igp_gate_t [2:0] cmd,
   output igp_gate_t [2:0]      sw,
   output logic                 fo_pull
);
   logic [2:0]      lo_lat = 3'h0;
   // High side starts latched off until a fresh ON edge arrives with its supply good
   logic [2:0]      hi_lat = 3'h7;
   igp_gate_t [2:0] prev = '0;
   int              fo_c = 0;
   wire             trip = sc || uvl;
   always @(posedge clk) begin
      prev <= cmd;
      for (int i = 0; i < 3; i++) begin
         if (trip) lo_lat[i] <= 1'b1;
         else if (fo_c == 0 && cmd[i].lo_gate && !prev[i].lo_gate)
            lo_lat[i] <= 1'b0;
         if (uvh[i]) hi_lat[i] <= 1'b1;
         else if (cmd[i].hi_gate && !prev[i].hi_gate)
            hi_lat[i] <= 1'b0;
      end
      if (trip) fo_c <= FO_CYC;
      else if (fo_c > 0) fo_c <= fo_c - 1;
   end
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         sw[i].lo_gate = cmd[i].lo_gate && !lo_lat[i]
                         && !trip;
         sw[i].hi_gate = cmd[i].hi_gate && !hi_lat[i]
                         && !uvh[i];
      end
   end
   assign fo_pull = fo_c > 0 || uvl;
endmodule

/* test/igp_host_bench.sv */
`timescale 1ns/1ns
module igp_host_bench import igp_pkg::*;;
   logic            clk = 1'b0;
   logic            rst_n = 1'b0;
   logic            sc = 1'b0;
   logic            uvl = 1'b0;
   logic [2:0]      uvh = 3'h7;
   igp_cmd_t [2:0]  req = '0;
   igp_gate_t [2:0] gate;
   igp_gate_t [2:0] sw;
   logic            pin, fout, foe, seen, evt, pull;
   int              n_mismatch = 0;
   int              tests_run = 0;
   always #5 clk = ~clk;
   // Pull-up wins unless someone sinks the pin
   assign pin = !pull && (foe || fout);
   igp_host dut (.clk(clk), .rst_n(rst_n), .pwm_req(req), .gate(gate),
      .fault_out_n_in(pin), .fault_out_n_out(fout),
      .fault_out_n_oe(foe), .fault_seen(seen), .fault_event(evt));
   igp_pm pm (.clk(clk), .sc(sc), .uvl(uvl), .uvh(uvh), .cmd(gate),
      .sw(sw), .fo_pull(pull));
   task chk(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task t_min_on;
      req[0].lo_on <= 1'b1;
      wt(10);
      req[0].lo_on <= 1'b0;
      chk(gate[0].lo_gate, 1'b1);
      wt(185);
      chk(gate[0].lo_gate, 1'b1);
      wt(15);
      chk(gate[0].lo_gate, 1'b0);
   endtask
   task t_blank;
      req[0].hi_on <= 1'b1;
      wt(280);
      chk(gate[0].hi_gate, 1'b0);
      for (int i = 0; i < 60 && gate[0].hi_gate !== 1'b1; i++) wt(1);
      chk(gate[0].hi_gate, 1'b1);
      wt(2);
      chk(sw[0].hi_gate, 1'b1);
   endtask
   task t_fault;
      req[1].lo_on <= 1'b1;
      wt(5);
      chk(gate[1].lo_gate, 1'b1);
      sc <= 1'b1;
      wt(1);
      sc <= 1'b0;
      chk(sw[1].lo_gate, 1'b0);
      chk(sw[0].hi_gate, 1'b1);
      wt(6);
      chk(seen, 1'b1);
      chk(gate[1].lo_gate | gate[0].hi_gate, 1'b0);
      for (int i = 0; i < 900 && gate[1].lo_gate !== 1'b1; i++) wt(1);
      wt(3);
      chk(sw[1].lo_gate, 1'b1);
   endtask
   task t_uv;
      uvh[0] <= 1'b1;
      wt(3);
      chk(sw[0].hi_gate, 1'b0);
      chk(seen, 1'b0);
      uvl <= 1'b1;
      wt(3);
      // Event pulse stands one cycle; look mid-cycle
      @(negedge clk);
      chk(evt, 1'b1);
      chk(fout, 1'b1);
      wt(5);
      chk(sw[1].lo_gate, 1'b0);
      chk(seen, 1'b1);
      uvl <= 1'b0;
      uvh[0] <= 1'b0;
   endtask
   initial begin
      wt(12);
      rst_n <= 1'b1;
      uvh <= 3'h0;
      wt(2);
      t_min_on;
      t_blank;
      t_fault;
      t_uv;
      wt(20);
      wrap_up;
   end
   initial begin
      #40000;
      n_mismatch++;
      wrap_up;
   end
endmodule
